// ---- logic/suf_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the
//          unknown-forwarding policy registers.
// Assumes: 8-bit registers on the switch register access port.
// Notes:   Included by bare name; definitions only.
`ifndef SUF_DEFS_SVH
`define SUF_DEFS_SVH

// Register offsets
`define SUF_ADDR_UNK_MCAST 8'h84
`define SUF_ADDR_UNK_VLAN 8'h85
`define SUF_ADDR_SELF_IPMC 8'h86
`define SUF_ADDR_RATE_TAG 8'h87

// Field positions
`define SUF_FWD_EN_BIT 5
`define SUF_MAP_MSB 4
`define SUF_SELF_EN_BIT 6
`define SUF_PERIOD_MSB 5
`define SUF_PERIOD_LSB 4
`define SUF_QUEUE_RL_BIT 3
`define SUF_PVID_SEL_BIT 2

// Reset values, reserved bits included
`define SUF_RST_UNK_MCAST 8'h40
`define SUF_RST_UNK_VLAN 8'h00
`define SUF_RST_SELF_IPMC 8'h00
`define SUF_RST_RATE_TAG 8'h10

// Writable bits of each register
`define SUF_WMASK_UNK_MCAST 8'h3F
`define SUF_WMASK_UNK_VLAN 8'h3F
`define SUF_WMASK_SELF_IPMC 8'h7F
`define SUF_WMASK_RATE_TAG 8'h3C

// Period select codes
`define SUF_PERIOD_16 2'h0
`define SUF_PERIOD_64 2'h1

// Timing: clock in kHz and unit periods in ms
`define SUF_CLK_KHZ 25000
`define SUF_T16_MS 16
`define SUF_T64_MS 64
`define SUF_T256_MS 256
`define SUF_T16_CYC (`SUF_T16_MS * `SUF_CLK_KHZ)
`define SUF_T64_CYC (`SUF_T64_MS * `SUF_CLK_KHZ)
`define SUF_T256_CYC (`SUF_T256_MS * `SUF_CLK_KHZ)

`endif

// ---- logic/suf_pkg.sv ----
// Purpose: Types shared by the unknown-forwarding policy block.
// Assumes: Five switch ports, port n+1 on mask bit n.
// Notes:   Constants live in suf_defs.svh.
package suf_pkg;

    typedef logic [4:0] suf_port_mask_t;

    typedef enum logic [2:0] {
        SUF_CLS_KNOWN,
        SUF_CLS_UNK_MCAST,
        SUF_CLS_UNK_VLAN,
        SUF_CLS_UNK_IPMC,
        SUF_CLS_OTHER
    } suf_pkt_class_e;

endpackage

// ---- logic/suf_fwd_map.sv ----
// Purpose: Turns one enable plus 5-bit port map into an egress port mask.
// Assumes: Map bit n selects switch port n+1.
// Notes:   When disabled the caller's default mask passes through.
`timescale 1ns/1ps

module suf_fwd_map (
    input wire logic fwdEn,
    input wire suf_pkg::suf_port_mask_t portMap,
    input wire suf_pkg::suf_port_mask_t defaultMask,
    output suf_pkg::suf_port_mask_t egressMask,
    output logic policyUsed
);
    import suf_pkg::*;

    always_comb begin
        policyUsed = fwdEn;
        if (fwdEn) begin
            // All zeros drops, all ones floods all five ports
            egressMask = portMap;
        end else begin
            egressMask = defaultMask;
        end
    end

endmodule

// ---- logic/suf_rate_tick.sv ----
// Purpose: Ingress rate-limit unit period tick generator.
// Assumes: Counts are in clk cycles, selected by a 2-bit code.
// Notes:   A shorter new period takes effect at once.
`timescale 1ns/1ps
`include "suf_defs.svh"

module suf_rate_tick #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] CYC16 = CNT_W'(`SUF_T16_CYC),
    parameter logic [CNT_W-1:0] CYC64 = CNT_W'(`SUF_T64_CYC),
    parameter logic [CNT_W-1:0] CYC256 = CNT_W'(`SUF_T256_CYC)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] periodSel,
    output logic periodTick
);
    import suf_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic [CNT_W-1:0] limit;

    always_comb begin
        if (periodSel[1]) begin
            limit = CYC256;
        end else if (periodSel == `SUF_PERIOD_64) begin
            limit = CYC64;
        end else begin
            limit = CYC16;
        end
        tick_d = 1'b0;
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q >= limit - CNT_W'(1)) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign periodTick = tick_q;

endmodule

// ---- logic/suf_policy_regs.sv ----
// Purpose: Global unknown-traffic forwarding policy registers and the
//          per-packet egress decision they steer.
// Assumes: Register port is the switch's internal 8-bit access path.
// Notes:   Decisions and read data appear one clock after the request.
//          A disabled policy keeps the lookup mask, and the self
//          filter covers every class and empties the mask.
//          Source ports past the last port never ask for a tag.
//          Reserved bits are held constants that writes cannot move.
//
// Overview of operation
// (RL1) Bit 5 at 0x84 enables unknown multicast forwarding
// (RL2) 0x84 map picks ports, zero drops
// (RL3) Bit 5 at 0x85 enables unknown VLAN forwarding
// (RL4) 0x85 map picks ports, zero drops
// (RL5) Bit 6 at 0x86 drops own-address packets
// (RL6) Self filter at egress, own MAC compared
// (RL7) Bit 5 at 0x86 enables unknown IP multicast
// (RL8) 0x86 map picks ports, zero drops
// (RL9) 0x87 bits 5:4 choose 16/64/256 ms
// (RL10) 0x87 bit 3 selects queue-based egress limits
// (RL11) 0x87 bit 2 set: per-source tag insertion
// (RL12) Bit clear: insert per port control zero
// (RL13) Host leaves reserved bits; they read fixed
// (RL14) Map bit n means switch port n+1
`timescale 1ns/1ps
`include "suf_defs.svh"

module suf_policy_regs #(
    parameter int NPORT = 5,
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] CYC16 = CNT_W'(`SUF_T16_CYC),
    parameter logic [CNT_W-1:0] CYC64 = CNT_W'(`SUF_T64_CYC),
    parameter logic [CNT_W-1:0] CYC256 = CNT_W'(`SUF_T256_CYC)
) (
    input wire logic clk,
    input wire logic nrst,
    // Register access
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRdValid,
    output logic regHit,
    // Own MAC address from the address registers
    input wire logic [47:0] ownMac,
    // Per-port tag settings from the port control registers
    input wire suf_pkg::suf_port_mask_t pvidInsertPort,
    input wire logic [24:0] pvidInsertMatrix,
    // Lookup result for one packet
    input wire logic pktValid,
    input wire suf_pkg::suf_pkt_class_e pktClass,
    input wire logic [2:0] pktSrcPort,
    input wire logic [47:0] pktDstMac,
    input wire suf_pkg::suf_port_mask_t pktLookupMask,
    // Egress decision
    output logic decValid,
    output suf_pkg::suf_port_mask_t decEgressMask,
    output suf_pkg::suf_port_mask_t decInsertTag,
    output logic decSelfDrop,
    output logic decPolicyUsed,
    // Global settings to the rate limiters
    output logic queueEgressLimit,
    output logic [1:0] ingressPeriodSel,
    output logic ingressPeriodTick
);
    import suf_pkg::*;

    // Register group
    logic [7:0] unkMcast_q;
    logic [7:0] unkMcast_d;
    logic [7:0] unkVlan_q;
    logic [7:0] unkVlan_d;
    logic [7:0] selfIpmc_q;
    logic [7:0] selfIpmc_d;
    logic [7:0] rateTag_q;
    logic [7:0] rateTag_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rdValid_q;
    logic rdValid_d;

    // Decision group
    logic decValid_q;
    logic decValid_d;
    suf_port_mask_t decMask_q;
    suf_port_mask_t decMask_d;
    suf_port_mask_t decTag_q;
    suf_port_mask_t decTag_d;
    logic decSelf_q;
    logic decSelf_d;
    logic decPol_q;
    logic decPol_d;
    logic queueRl_q;
    logic queueRl_d;

    // Resolver results
    suf_port_mask_t mcastMask;
    suf_port_mask_t vlanMask;
    suf_port_mask_t ipmcMask;
    logic mcastUsed;
    logic vlanUsed;
    logic ipmcUsed;
    logic addrHit;
    logic srcInRange;

    // Decode of the four registers
    always_comb begin
        case (regAddr)
            `SUF_ADDR_UNK_MCAST: addrHit = 1'b1;
            `SUF_ADDR_UNK_VLAN: addrHit = 1'b1;
            `SUF_ADDR_SELF_IPMC: addrHit = 1'b1;
            `SUF_ADDR_RATE_TAG: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    assign regHit = addrHit;

    // Source port known to the tag tables
    assign srcInRange = pktSrcPort < 3'(NPORT);

    // Writes and registered reads
    always_comb begin
        unkMcast_d = unkMcast_q;
        unkVlan_d = unkVlan_q;
        selfIpmc_d = selfIpmc_q;
        rateTag_d = rateTag_q;
        rdata_d = rdata_q;
        // Read strobe answered on the next clock
        rdValid_d = regRd;

        if (regWr) begin
            // (RL13) reserved bits kept
            case (regAddr)
                `SUF_ADDR_UNK_MCAST: begin
                    unkMcast_d = (regWdata & `SUF_WMASK_UNK_MCAST) | (`SUF_RST_UNK_MCAST & ~`SUF_WMASK_UNK_MCAST);
                end
                `SUF_ADDR_UNK_VLAN: begin
                    unkVlan_d = (regWdata & `SUF_WMASK_UNK_VLAN) | (`SUF_RST_UNK_VLAN & ~`SUF_WMASK_UNK_VLAN);
                end
                `SUF_ADDR_SELF_IPMC: begin
                    selfIpmc_d = (regWdata & `SUF_WMASK_SELF_IPMC) | (`SUF_RST_SELF_IPMC & ~`SUF_WMASK_SELF_IPMC);
                end
                `SUF_ADDR_RATE_TAG: begin
                    rateTag_d = (regWdata & `SUF_WMASK_RATE_TAG) | (`SUF_RST_RATE_TAG & ~`SUF_WMASK_RATE_TAG);
                end
                default: begin
                end
            endcase
        end

        // (RL13) reserved bits read fixed
        // Reads see the value from before a same-cycle write
        if (regRd) begin
            case (regAddr)
                `SUF_ADDR_UNK_MCAST: rdata_d = unkMcast_q;
                `SUF_ADDR_UNK_VLAN: rdata_d = unkVlan_q;
                `SUF_ADDR_SELF_IPMC: rdata_d = selfIpmc_q;
                `SUF_ADDR_RATE_TAG: rdata_d = rateTag_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Reserved bits start at their fixed values
    always_ff @(posedge clk) begin
        if (!nrst) begin
            unkMcast_q <= `SUF_RST_UNK_MCAST;
            unkVlan_q <= `SUF_RST_UNK_VLAN;
            selfIpmc_q <= `SUF_RST_SELF_IPMC;
            rateTag_q <= `SUF_RST_RATE_TAG;
            rdata_q <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            unkMcast_q <= unkMcast_d;
            unkVlan_q <= unkVlan_d;
            selfIpmc_q <= selfIpmc_d;
            rateTag_q <= rateTag_d;
            rdata_q <= rdata_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdata = rdata_q;
    assign regRdValid = rdValid_q;

    // (RL1) (RL2) (RL14) unknown multicast map
    suf_fwd_map u_mcast (
        .fwdEn(unkMcast_q[`SUF_FWD_EN_BIT]),
        .portMap(unkMcast_q[`SUF_MAP_MSB:0]),
        .defaultMask(pktLookupMask),
        .egressMask(mcastMask),
        .policyUsed(mcastUsed)
    );

    // (RL3) (RL4) unknown VLAN map
    suf_fwd_map u_vlan (
        .fwdEn(unkVlan_q[`SUF_FWD_EN_BIT]),
        .portMap(unkVlan_q[`SUF_MAP_MSB:0]),
        .defaultMask(pktLookupMask),
        .egressMask(vlanMask),
        .policyUsed(vlanUsed)
    );

    // (RL7) (RL8) unknown IP multicast map
    suf_fwd_map u_ipmc (
        .fwdEn(selfIpmc_q[`SUF_FWD_EN_BIT]),
        .portMap(selfIpmc_q[`SUF_MAP_MSB:0]),
        .defaultMask(pktLookupMask),
        .egressMask(ipmcMask),
        .policyUsed(ipmcUsed)
    );

    // Per-packet decision
    always_comb begin
        decValid_d = pktValid;
        decMask_d = decMask_q;
        decTag_d = decTag_q;
        decSelf_d = decSelf_q;
        decPol_d = decPol_q;
        queueRl_d = rateTag_q[`SUF_QUEUE_RL_BIT];
        // Decision fields hold between requests; decValid follows pktValid
        if (pktValid) begin
            // An enabled policy replaces the lookup mask
            case (pktClass)
                SUF_CLS_UNK_MCAST: begin
                    decMask_d = mcastMask;
                    decPol_d = mcastUsed;
                end
                SUF_CLS_UNK_VLAN: begin
                    decMask_d = vlanMask;
                    decPol_d = vlanUsed;
                end
                SUF_CLS_UNK_IPMC: begin
                    decMask_d = ipmcMask;
                    decPol_d = ipmcUsed;
                end
                default: begin
                    decMask_d = pktLookupMask;
                    decPol_d = 1'b0;
                end
            endcase

            // (RL5) (RL6) own address dropped at egress
            decSelf_d = selfIpmc_q[`SUF_SELF_EN_BIT] && (pktDstMac == ownMac);
            // Self filter overrides any policy map
            if (decSelf_d) begin
                decMask_d = '0;
            end

            if (rateTag_q[`SUF_PVID_SEL_BIT]) begin
                // (RL11) per source port choice
                decTag_d = srcInRange ? pvidInsertMatrix[pktSrcPort * NPORT +: NPORT] : '0;
            end else begin
                // (RL12) source port control zero
                decTag_d = (srcInRange && pvidInsertPort[pktSrcPort]) ? '1 : '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            decValid_q <= 1'b0;
            decMask_q <= '0;
            decTag_q <= '0;
            decSelf_q <= 1'b0;
            decPol_q <= 1'b0;
            queueRl_q <= 1'b0;
        end else begin
            decValid_q <= decValid_d;
            decMask_q <= decMask_d;
            decTag_q <= decTag_d;
            decSelf_q <= decSelf_d;
            decPol_q <= decPol_d;
            queueRl_q <= queueRl_d;
        end
    end

    // Decision data stands until the next packet
    assign decValid = decValid_q;
    assign decEgressMask = decMask_q;
    assign decInsertTag = decTag_q;
    assign decSelfDrop = decSelf_q;
    assign decPolicyUsed = decPol_q;

    // (RL10) egress limit scheme
    assign queueEgressLimit = queueRl_q;
    // Period select feeds the limiters straight from the register
    assign ingressPeriodSel = rateTag_q[`SUF_PERIOD_MSB:`SUF_PERIOD_LSB];

    // (RL9) unit period tick
    suf_rate_tick #(
        .CNT_W(CNT_W),
        .CYC16(CYC16),
        .CYC64(CYC64),
        .CYC256(CYC256)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .periodSel(rateTag_q[`SUF_PERIOD_MSB:`SUF_PERIOD_LSB]),
        .periodTick(ingressPeriodTick)
    );

endmodule

// ---- tb/suf_policy_asserts.sv ----
// Purpose: Port-level checks of the policy register block.
// Assumes: Unit periods of at least 10 cycles.
// Notes:   Register contents are hidden, so outputs are tied to requests.
`timescale 1ns/1ps

module suf_policy_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    input wire logic [47:0] ownMac,
    input wire logic pktValid,
    input wire suf_pkg::suf_pkt_class_e pktClass,
    input wire logic [47:0] pktDstMac,
    input wire suf_pkg::suf_port_mask_t pktLookupMask,
    input wire logic decValid,
    input wire suf_pkg::suf_port_mask_t decEgressMask,
    input wire logic decSelfDrop,
    input wire logic decPolicyUsed,
    input wire logic queueEgressLimit,
    input wire logic [1:0] ingressPeriodSel,
    input wire logic ingressPeriodTick
);
    import suf_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_rsv84;
        regRd && regAddr == 8'h84 |=> regRdValid && regRdata[7:6] == 2'b01;
    endproperty
    a_rsv84: assert property (p_rsv84) else $error("0x84 fixed bits wrong");
    property p_rsv87;
        regRd && regAddr == 8'h87 |=> regRdValid && regRdata[7:6] == 2'b00 && regRdata[1:0] == 2'b00;
    endproperty
    a_rsv87: assert property (p_rsv87) else $error("0x87 fixed bits wrong");
    property p_unmap;
        regRd && !(regAddr inside {[8'h84:8'h87]}) |=> regRdValid && regRdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_known;
        pktValid && pktClass == SUF_CLS_KNOWN && pktDstMac != ownMac
            |=> decValid && !decPolicyUsed && decEgressMask == $past(pktLookupMask);
    endproperty
    a_known: assert property (p_known) else $error("known packet mask changed");
    property p_selfmask;
        decSelfDrop |-> decEgressMask == 5'h00;
    endproperty
    a_selfmask: assert property (p_selfmask) else $error("self drop with egress ports");
    property p_selfmac;
        pktValid && pktDstMac != ownMac |=> !decSelfDrop;
    endproperty
    a_selfmac: assert property (p_selfmac) else $error("self drop on foreign address");
    property p_queue;
        regWr && regAddr == 8'h87 |=> ##1 queueEgressLimit == $past(regWdata[3], 2);
    endproperty
    a_queue: assert property (p_queue) else $error("egress limit scheme not followed");
    property p_psel;
        regWr && regAddr == 8'h87 ##1 !regWr |=> ingressPeriodSel == $past(regWdata[5:4], 2);
    endproperty
    a_psel: assert property (p_psel) else $error("period select not followed");
    property p_tick;
        ingressPeriodTick |=> !ingressPeriodTick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("period ticks too close");
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the policy register block.
// Assumes: Unit periods shortened to 10/20/40 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps

bind suf_policy_regs suf_policy_asserts u_chk (.clk, .nrst, .regAddr, .regWr, .regRd, .regWdata,
    .regRdata, .regRdValid, .ownMac, .pktValid, .pktClass, .pktDstMac, .pktLookupMask, .decValid,
    .decEgressMask, .decSelfDrop, .decPolicyUsed, .queueEgressLimit, .ingressPeriodSel,
    .ingressPeriodTick);

module tb;
    import suf_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic regRdValid, regHit, decValid, decSelfDrop, decPolicyUsed, queueEgressLimit, ingressPeriodTick;
    logic [47:0] ownMac = 48'h0A1B2C3D4E5F;
    suf_port_mask_t pvidInsertPort = 5'h05;
    logic [24:0] pvidInsertMatrix = {5'h11, 5'h0A, 5'h15, 5'h03, 5'h1C};
    logic pktValid = 1'b0;
    suf_pkt_class_e pktClass = SUF_CLS_KNOWN;
    logic [2:0] pktSrcPort = 3'h0;
    logic [47:0] pktDstMac = 48'h000000000001;
    suf_port_mask_t pktLookupMask = 5'h00;
    suf_port_mask_t decEgressMask, decInsertTag;
    logic [1:0] ingressPeriodSel;
    int n_errors = 0;
    int num_checks = 0;
    logic [7:0] rstv [4] = '{8'h40, 8'h00, 8'h00, 8'h10};
    logic [7:0] onev [4] = '{8'h7F, 8'h3F, 8'h7F, 8'h3C};
    logic [7:0] zerov [4] = '{8'h40, 8'h00, 8'h00, 8'h00};
    int pcyc [4] = '{10, 20, 40, 40};

    always #20 clk = ~clk;

    suf_policy_regs #(.CYC16(24'h00000A), .CYC64(24'h000014), .CYC256(24'h000028)) dut (.clk, .nrst,
        .regAddr, .regWr, .regRd, .regWdata, .regRdata, .regRdValid, .regHit, .ownMac, .pvidInsertPort,
        .pvidInsertMatrix, .pktValid, .pktClass, .pktSrcPort, .pktDstMac, .pktLookupMask, .decValid,
        .decEgressMask, .decInsertTag, .decSelfDrop, .decPolicyUsed, .queueEgressLimit,
        .ingressPeriodSel, .ingressPeriodTick);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Strobes drop after the taking edge; one idle cycle between requests
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(posedge clk);
        #1 regWr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        regRd = 1'b1;
        #1 chk(16'(regHit), 16'(a >= 8'h84 && a <= 8'h87));
        @(posedge clk);
        #1 regRd = 1'b0;
        chk({regRdValid, regRdata}, {1'b1, e});
        @(posedge clk);
        #1;
    endtask

    // Expected value packs mask, tag mask, self drop and policy flag
    task automatic pk(input suf_pkt_class_e c, input logic [2:0] s, input logic [47:0] d,
                      input logic [11:0] e);
        pktClass = c;
        pktSrcPort = s;
        pktDstMac = d;
        pktLookupMask = 5'h0C;
        pktValid = 1'b1;
        @(posedge clk);
        #1 pktValid = 1'b0;
        chk({decValid, decEgressMask, decInsertTag, decSelfDrop, decPolicyUsed}, {1'b1, e});
        @(posedge clk);
        #1;
    endtask

    // Syncs to one tick, then counts cycles to the next
    task automatic tk(input int e);
        int n;
        n = 0;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            #1 n = 1;
            while (ingressPeriodTick !== 1'b1 && n < 100) begin
                @(posedge clk);
                #1 n++;
            end
        end
        chk(16'(n), 16'(e));
    endtask

    initial begin
        #400000;
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(132 + i), rstv[i]);
            wr(8'(132 + i), 8'hFF);
            rd(8'(132 + i), onev[i]);
            wr(8'(132 + i), 8'h00);
            rd(8'(132 + i), zerov[i]);
        end
        wr(8'h88, 8'hFF);
        rd(8'h88, 8'h00);
        rd(8'h83, 8'h00);
        rd(8'h84, 8'h40);
        $display("register test done");
        pk(SUF_CLS_KNOWN, 3'h0, 48'h1, {5'h0C, 5'h1F, 2'b00});
        pk(SUF_CLS_UNK_MCAST, 3'h1, 48'h1, {5'h0C, 5'h00, 2'b00});
        wr(8'h84, 8'h23);
        pk(SUF_CLS_UNK_MCAST, 3'h1, 48'h1, {5'h03, 5'h00, 2'b01});
        wr(8'h84, 8'h20);
        pk(SUF_CLS_UNK_MCAST, 3'h1, 48'h1, {5'h00, 5'h00, 2'b01});
        wr(8'h85, 8'h1F);
        pk(SUF_CLS_UNK_VLAN, 3'h2, 48'h1, {5'h0C, 5'h1F, 2'b00});
        wr(8'h85, 8'h3F);
        pk(SUF_CLS_UNK_VLAN, 3'h2, 48'h1, {5'h1F, 5'h1F, 2'b01});
        pk(SUF_CLS_UNK_IPMC, 3'h1, 48'h1, {5'h0C, 5'h00, 2'b00});
        wr(8'h86, 8'h27);
        pk(SUF_CLS_UNK_IPMC, 3'h1, 48'h1, {5'h07, 5'h00, 2'b01});
        pk(SUF_CLS_OTHER, 3'h1, 48'h1, {5'h0C, 5'h00, 2'b00});
        pk(SUF_CLS_KNOWN, 3'h1, ownMac, {5'h0C, 5'h00, 2'b00});
        wr(8'h86, 8'h67);
        pk(SUF_CLS_KNOWN, 3'h1, ownMac, {5'h00, 5'h00, 2'b10});
        pk(SUF_CLS_KNOWN, 3'h5, 48'h1, {5'h0C, 5'h00, 2'b00});
        wr(8'h87, 8'h04);
        for (int s = 0; s < 5; s++) begin
            pk(SUF_CLS_KNOWN, 3'(s), 48'h1, {5'h0C, pvidInsertMatrix[s*5+:5], 2'b00});
        end
        $display("packet test done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h87, {2'b00, 2'(c), 4'h8});
            chk({queueEgressLimit, ingressPeriodSel}, {1'b1, 2'(c)});
            tk(pcyc[c]);
        end
        wr(8'h87, 8'h10);
        chk({queueEgressLimit, ingressPeriodSel}, 16'h0001);
        $display("rate test done");
        // Mid-run reset brings back the defaults
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({decValid, decEgressMask, decInsertTag, decSelfDrop, decPolicyUsed, queueEgressLimit,
            ingressPeriodSel}, 16'h0001);
        chk({regRdValid, regRdata, ingressPeriodTick}, 16'h0000);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(132 + i), rstv[i]);
        end
        tk(pcyc[1]);
        $display("reset test done");
        end_sim();
    end
endmodule
